// ---- rtl/cpt_top.sv ----
// Configuration completion flag, reconfiguration pin and test port
`timescale 1ns/1ps
`include "cpt_defs.svh"
module cpt_top import cpt_pkg::*; #(
  parameter int W          = 32,
  parameter int FIFO_DEPTH = 16,
  parameter int CFG_WORDS  = 16,
  parameter int DRAIN_GAP  = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         crstReqN,
  input  wire logic         cdoneIn,
  output wire logic         cdoneOut,
  output wire logic         cdoneOe,
  input  wire logic         tck,
  input  wire logic         tmsIn,
  input  wire logic         tmsDrv,
  input  wire logic         tdiIn,
  input  wire logic         tdiDrv,
  output wire logic         tdoOut,
  output wire logic         tdoOe,
  output wire logic [W-1:0] cfgData,
  output wire logic         cfgDataValid,
  output wire logic         configDone,
  output wire logic         userMode
);
  localparam int IRW = `CPT_IR_W;
  localparam logic [10:0] TUSER_LAST  = 11'(`CPT_TUSER_CYC - 1);
  localparam logic [4:0]  CRST_MIN    = 5'(`CPT_CRST_MIN_CYC);
  localparam logic [7:0]  GAP_LAST    = 8'(DRAIN_GAP - 1);
  localparam logic [15:0] WORDS_LAST  = 16'(CFG_WORDS - 1);

  // ----------------------------------------------------------------
  // Test clock domain state
  // ----------------------------------------------------------------
  cpt_tap_type    tap_r, tap_nxt;
  logic [IRW-1:0] ir_r, ir_nxt, irSh_r, irSh_nxt;
  logic [W-1:0]   dr_r, dr_nxt, hold_r, hold_nxt;
  logic           byp_r, byp_nxt, reqT_r, reqT_nxt, euT_r, euT_nxt;
  logic           tdo_r, tdo_nxt, tdoEn_r, tdoEn_nxt;
  logic           ackT1_r, ackT2_r, doneT1_r, doneT2_r, userT1_r, userT2_r;
  logic           tmsEff, tdiEff, busyT;
  logic [W-1:0]   statWord;

  // ----------------------------------------------------------------
  // System clock domain state
  // ----------------------------------------------------------------
  cpt_cfg_type  st_r, st_nxt;
  logic         crs1_r, crs2_r, crsPrev_r, cdn1_r, cdn2_r;
  logic         req1_r, req2_r, eu1_r, eu2_r, eu3_r;
  logic         ack_r, ack_nxt, euSeen_r, euSeen_nxt;
  logic [4:0]   low_r, low_nxt;
  logic [7:0]   gap_r, gap_nxt;
  logic [15:0]  words_r, words_nxt;
  logic [10:0]  dly_r, dly_nxt;
  logic [W-1:0] cfgData_r, cfgData_nxt;
  logic         cfgVal_r, cfgVal_nxt, done_r, done_nxt, user_r, user_nxt;
  logic         trigger, pend, euEvent;

  cpt_stream_if #(.W(W)) pushIf ();
  cpt_stream_if #(.W(W)) popIf ();

  // Standard controller transitions
  function automatic cpt_tap_type tapNext(input cpt_tap_type s,
                                          input logic m);
    case (s)
      TAP_RESET:  tapNext = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tapNext = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tapNext = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tapNext = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tapNext = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tapNext = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tapNext = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tapNext = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tapNext = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
      default:    tapNext = TAP_RESET;
    endcase
  endfunction

  // Shift one bit into the top of a register whose length the given instruction selects
  function automatic logic [W-1:0] drShift(input logic [W-1:0] s,
                                           input logic b,
                                           input logic [IRW-1:0] ir);
    drShift = s >> 1;
    if (ir == `CPT_IR_STATUS) begin
      drShift[`CPT_STAT_LEN-1] = b;
    end else begin
      drShift[W-1] = b;
    end
  endfunction

  // Weak pull-ups on the mode-select and data input pins
  assign tmsEff = tmsIn | ~tmsDrv;
  assign tdiEff = tdiIn | ~tdiDrv;
  assign busyT  = reqT_r ^ ackT2_r;

  always_comb begin
    statWord                 = '0;
    statWord[`CPT_STAT_BUSY] = busyT;
    statWord[`CPT_STAT_DONE] = doneT2_r;
    statWord[`CPT_STAT_USER] = userT2_r;
  end

  // ----------------------------------------------------------------
  // Test controller and shift registers, rising test clock
  // ----------------------------------------------------------------
  always_comb begin
    tap_nxt  = tapNext(tap_r, tmsEff);
    ir_nxt   = ir_r;
    irSh_nxt = irSh_r;
    dr_nxt   = dr_r;
    byp_nxt  = byp_r;
    hold_nxt = hold_r;
    reqT_nxt = reqT_r;
    euT_nxt  = euT_r;
    case (tap_r)
      TAP_RESET: begin
        ir_nxt = `CPT_IR_BYPASS;
      end
      TAP_CAP_IR: begin
        irSh_nxt = `CPT_IR_CAPTURE;
      end
      TAP_SH_IR: begin
        irSh_nxt = {tdiEff, irSh_r[IRW-1:1]};
      end
      TAP_UPD_IR: begin
        ir_nxt = irSh_r;
        if (irSh_r == `CPT_IR_ENTER_USER) begin
          euT_nxt = ~euT_r;
        end
      end
      TAP_CAP_DR: begin
        byp_nxt = 1'b0;
        dr_nxt  = (ir_r == `CPT_IR_STATUS) ? statWord : '0;
      end
      TAP_SH_DR: begin
        byp_nxt = tdiEff;
        dr_nxt  = drShift(dr_r, tdiEff, ir_r);
      end
      TAP_UPD_DR: begin
        if (ir_r == `CPT_IR_CFG_LOAD && !busyT) begin
          hold_nxt = dr_r;
          reqT_nxt = ~reqT_r;
        end
      end
      default: ;
    endcase
  end

  // Registers sampling mode-select and data on the rising edge
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tap_r  <= TAP_RESET;
      ir_r   <= `CPT_IR_BYPASS;
      irSh_r <= '0;
      dr_r   <= '0;
      byp_r  <= 1'b0;
      hold_r <= '0;
      reqT_r <= 1'b0;
      euT_r  <= 1'b0;
    end else begin
      tap_r  <= tap_nxt;
      ir_r   <= ir_nxt;
      irSh_r <= irSh_nxt;
      dr_r   <= dr_nxt;
      byp_r  <= byp_nxt;
      hold_r <= hold_nxt;
      reqT_r <= reqT_nxt;
      euT_r  <= euT_nxt;
    end
  end

  // Crossings into the test clock domain
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      {ackT1_r, ackT2_r}   <= 2'h0;
      {doneT1_r, doneT2_r} <= 2'h0;
      {userT1_r, userT2_r} <= 2'h0;
    end else begin
      {ackT1_r, ackT2_r}   <= {ack_r, ackT1_r};
      {doneT1_r, doneT2_r} <= {done_r, doneT1_r};
      {userT1_r, userT2_r} <= {user_r, userT1_r};
    end
  end

  // ----------------------------------------------------------------
  // Serial output, falling test clock
  // ----------------------------------------------------------------
  always_comb begin
    tdo_nxt   = 1'b0;
    tdoEn_nxt = 1'b0;
    if (tap_r == TAP_SH_IR) begin
      tdo_nxt   = irSh_r[0];
      tdoEn_nxt = 1'b1;
    end else if (tap_r == TAP_SH_DR) begin
      tdo_nxt   = (ir_r == `CPT_IR_BYPASS) ? byp_r : dr_r[0];
      tdoEn_nxt = 1'b1;
    end
  end

  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_r   <= 1'b0;
      tdoEn_r <= 1'b0;
    end else begin
      tdo_r   <= tdo_nxt;
      tdoEn_r <= tdoEn_nxt;
    end
  end

  assign tdoOut = tdo_r;
  assign tdoOe  = tdoEn_r;

  // ----------------------------------------------------------------
  // Pin and event synchronisers, system clock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {crs1_r, crs2_r, crsPrev_r} <= 3'h7;
      {cdn1_r, cdn2_r}            <= 2'h0;
      {req1_r, req2_r}            <= 2'h0;
      {eu1_r, eu2_r, eu3_r}       <= 3'h0;
    end else begin
      {crs1_r, crs2_r, crsPrev_r} <= {crstReqN, crs1_r, crs2_r};
      {cdn1_r, cdn2_r}            <= {cdoneIn, cdn1_r};
      {req1_r, req2_r}            <= {reqT_r, req1_r};
      {eu1_r, eu2_r, eu3_r}       <= {euT_r, eu1_r, eu2_r};
    end
  end

  // Rising edge of a long enough low pulse restarts loading only
  assign trigger = crs2_r & ~crsPrev_r & (low_r >= CRST_MIN);
  assign euEvent = eu2_r ^ eu3_r;
  assign pend    = req2_r ^ ack_r;

  // Words from the test port enter the FIFO while loading
  assign pushIf.valid = pend & (st_r == CFG_LOAD);
  assign pushIf.data  = hold_r;
  assign popIf.ready  = (st_r == CFG_LOAD) && (gap_r == '0);

  cpt_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .inIf    (pushIf),
    .outIf   (popIf)
  );

  // ----------------------------------------------------------------
  // Configuration sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    low_nxt     = crs2_r ? 5'h00 : ((low_r == 5'h1F) ? low_r : low_r + 1'b1);
    ack_nxt     = (pend && !(pushIf.valid && !pushIf.ready)) ? req2_r : ack_r;
    euSeen_nxt  = euEvent | (euSeen_r & ~trigger);
    gap_nxt     = (gap_r != '0) ? gap_r - 1'b1 : gap_r;
    words_nxt   = words_r;
    dly_nxt     = dly_r;
    cfgData_nxt = cfgData_r;
    cfgVal_nxt  = 1'b0;
    case (st_r)
      CFG_LOAD: begin
        if (popIf.valid && popIf.ready) begin
          cfgData_nxt = popIf.data;
          cfgVal_nxt  = 1'b1;
          gap_nxt     = GAP_LAST;
          words_nxt   = words_r + 1'b1;
          if (words_r == WORDS_LAST) begin
            st_nxt = CFG_WAIT;
          end
        end
      end
      CFG_WAIT: begin
        if (cdn2_r && euSeen_r) begin
          st_nxt  = CFG_DELAY;
          dly_nxt = TUSER_LAST;
        end
      end
      CFG_DELAY: begin
        if (!cdn2_r) begin
          st_nxt = CFG_WAIT;
        end else if (dly_r == '0) begin
          st_nxt = CFG_USER;
        end else begin
          dly_nxt = dly_r - 1'b1;
        end
      end
      CFG_USER: ;
      default: st_nxt = CFG_LOAD;
    endcase
    if (trigger) begin
      st_nxt    = CFG_LOAD;
      words_nxt = '0;
    end
    done_nxt = (st_nxt != CFG_LOAD);
    user_nxt = (st_nxt == CFG_USER);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= CFG_LOAD;
      low_r     <= '0;
      ack_r     <= 1'b0;
      euSeen_r  <= 1'b0;
      gap_r     <= '0;
      words_r   <= '0;
      dly_r     <= '0;
      cfgData_r <= '0;
      cfgVal_r  <= 1'b0;
      done_r    <= 1'b0;
      user_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      low_r     <= low_nxt;
      ack_r     <= ack_nxt;
      euSeen_r  <= euSeen_nxt;
      gap_r     <= gap_nxt;
      words_r   <= words_nxt;
      dly_r     <= dly_nxt;
      cfgData_r <= cfgData_nxt;
      cfgVal_r  <= cfgVal_nxt;
      done_r    <= done_nxt;
      user_r    <= user_nxt;
    end
  end

  // Open-drain flag: only ever pulls low
  assign cdoneOut     = 1'b0;
  assign cdoneOe      = ~done_r;
  assign cfgData      = cfgData_r;
  assign cfgDataValid = cfgVal_r;
  assign configDone   = done_r;
  assign userMode     = user_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FLAG_OD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cdoneOut && (cdoneOe == (st_r == CFG_LOAD)))
    else $error("Completion flag not open-drain or wrong enable");
  AST_FLAG_REL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(cdoneOe) |-> $past(words_r) == WORDS_LAST)
    else $error("Flag released before last word");
  AST_HOLD_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!cdn2_r && !user_r && !trigger) |=> !user_r)
    else $error("User mode entered while flag held low");
  AST_DELAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(user_r) |-> $past(st_r == CFG_DELAY && dly_r == '0))
    else $error("User mode without full delay");
  AST_RECONF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trigger |=> (st_r == CFG_LOAD) && (words_r == '0) && !user_r)
    else $error("Reconfiguration did not restart loading");
  AST_TLR: assert property (@(posedge tck) disable iff (!rst_n)
    tmsEff [*5] |=> tap_r == TAP_RESET)
    else $error("Five ones on mode-select did not reset controller");
  AST_IR_IN: assert property (@(posedge tck) disable iff (!rst_n)
    tap_r == TAP_SH_IR |=> irSh_r[IRW-1] == $past(tdiEff))
    else $error("Instruction shift lost the input bit");
  AST_IR_OUT: assert property (@(posedge tck) disable iff (!rst_n)
    (tap_r == TAP_SH_IR && $past(tap_r) == TAP_SH_IR)
    |-> tdoOe && tdoOut == irSh_r[0])
    else $error("Serial output not from instruction path");
  AST_BYP_LEN: assert property (@(posedge tck) disable iff (!rst_n)
    ($past(tap_r) == TAP_SH_DR && tap_r == TAP_SH_DR
     && ir_r == `CPT_IR_BYPASS) |-> tdoOut == $past(tdiEff))
    else $error("Bypass delay is not one cycle");
  // Enable follows the state held since the last falling edge
  AST_TDO_OFF: assert property (@(posedge tck) disable iff (!rst_n)
    (tap_r != TAP_SH_DR && tap_r != TAP_SH_IR)
    |-> !tdoOe)
    else $error("Serial output driven outside shifting");
  CV_USER: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(user_r));
  CV_RECONF: cover property (@(posedge sys_clk) disable iff (!rst_n)
    trigger && st_r == CFG_USER);
  CV_ENTER: cover property (@(posedge tck) disable iff (!rst_n)
    tap_r == TAP_UPD_IR && irSh_r == `CPT_IR_ENTER_USER);
endmodule

// ---- rtl/cpt_defs.svh ----
// Constants of the configuration status and test access port block
`ifndef CPT_DEFS_SVH
`define CPT_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CPT_CLK_PERIOD_NS 20
`define CPT_TUSER_NS      25000
`define CPT_TUSER_CYC \
  ((`CPT_TUSER_NS + `CPT_CLK_PERIOD_NS - 1) / `CPT_CLK_PERIOD_NS)
`define CPT_CRST_MIN_NS   320
`define CPT_CRST_MIN_CYC \
  ((`CPT_CRST_MIN_NS + `CPT_CLK_PERIOD_NS - 1) / `CPT_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define CPT_IR_W          4
`define CPT_IR_CAPTURE    4'h1
`define CPT_IR_BYPASS     4'hF
`define CPT_IR_CFG_LOAD   4'h2
`define CPT_IR_STATUS     4'h3
`define CPT_IR_ENTER_USER 4'h7

// ----------------------------------------------------------------
// Status data register
// ----------------------------------------------------------------
`define CPT_STAT_LEN      8
`define CPT_STAT_BUSY     0
`define CPT_STAT_DONE     1
`define CPT_STAT_USER     2

`endif

// ---- rtl/cpt_pkg.sv ----
// Types of the configuration status and test access port block
package cpt_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } cpt_tap_type;

  typedef enum logic [1:0] {
    CFG_LOAD, CFG_WAIT, CFG_DELAY, CFG_USER
  } cpt_cfg_type;

endpackage

// ---- rtl/cpt_stream_if.sv ----
// Valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface cpt_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/cpt_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cpt_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  cpt_stream_if.snk inIf,
  cpt_stream_if.src outIf
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign inIf.ready  = (cnt_r != FULL);
  assign outIf.valid = (cnt_r != '0);
  assign outIf.data  = mem_r[rp_r];
  assign push        = inIf.valid & inIf.ready;
  assign pop         = outIf.valid & outIf.ready;

  // ----------------------------------------------------------------
  // Pointer and storage update
  // ----------------------------------------------------------------
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = inIf.data;
      wp_nxt        = bump(wp_r);
    end
    if (pop) begin
      rp_nxt = bump(rp_r);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Count must agree with the pointers; equal pointers mean empty or full
  AST_FIFO_NO_OVER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cnt_r <= FULL) && !((cnt_r == FULL) && inIf.ready)
    && ((wp_r == rp_r) == ((cnt_r == '0) || (cnt_r == FULL))))
    else $error("FIFO count disagrees with its pointers");
  COV_FIFO_FULL: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_r == FULL);
endmodule

// ---- sim/cpt_host_model.sv ----
// Test host model driving the test port pins
`timescale 1ns/1ps
module cpt_host_model (
  output logic      tck,
  output logic      tmsIn,
  output logic      tmsDrv,
  output logic      tdiIn,
  output logic      tdiDrv,
  input  wire logic tdoOut,
  input  wire logic tdoOe
);
  localparam realtime HALF = 62.5;

  // Test clock stands low between transfers
  initial begin
    tck    = 1'b0;
    tmsIn  = 1'b1;
    tmsDrv = 1'b1;
    tdiIn  = 1'b1;
    tdiDrv = 1'b1;
  end

  // One test clock cycle; inputs change just after the falling edge
  task automatic pulse(input logic tms, input logic tdi, input logic drv,
                       output logic tdo, output logic oe);
    tmsIn  = tms;
    tmsDrv = 1'b1;
    tdiDrv = drv;
    tdiIn  = drv ? tdi : ~tdiIn; // Released line toggles
    #HALF tck = 1'b1;
    tdo = tdoOut;
    oe  = tdoOe;
    #HALF tck = 1'b0;
    #1;
  endtask

  // Single controller step with mode-select value
  task automatic move(input logic tms);
    logic t;
    logic o;
    pulse(tms, 1'b1, 1'b1, t, o);
  endtask

  // Full scan from idle through update back to idle, LSB first
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
                      input logic drv, output logic [31:0] dout,
                      output logic oeAll);
    logic t;
    logic o;
    dout  = '0;
    oeAll = 1'b1;
    move(1'b1);
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], drv, t, o);
      dout[i] = t;
      oeAll   = oeAll & o;
    end
    move(1'b1);
    move(1'b0);
  endtask

  // Mode-select released for n cycles; the line toggles each cycle
  task automatic float_tms(input int n);
    for (int i = 0; i < n; i++) begin
      tmsDrv = 1'b0;
      tmsIn  = ~tmsIn;
      #HALF tck = 1'b1;
      #HALF tck = 1'b0;
      #1;
    end
    move(1'b0);
  endtask
endmodule

// ---- sim/config_status_and_tap_pins_tb.sv ----
// Self-checking bench of the configuration status and test port block
`timescale 1ns/1ps
`include "cpt_defs.svh"
module config_status_and_tap_pins_tb import cpt_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        rst_n, crstReqN, cdoneHold;
  wire  logic  cdoneIn;
  logic        cdoneOut, cdoneOe, tck, tmsIn, tmsDrv, tdiIn, tdiDrv;
  logic        tdoOut, tdoOe, cfgDataValid, configDone, userMode;
  logic [31:0] cfgData, d;
  logic        oe;
  logic [31:0] got [$];
  int          fail_count = 0;
  int          n_checks = 0;

  always #10 sys_clk = ~sys_clk;

  // Flag wire: pull-up, low when device or bench pulls it
  assign cdoneIn = ~(cdoneOe | cdoneHold);

  cpt_top #(.CFG_WORDS(2)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .crstReqN(crstReqN), .cdoneIn(cdoneIn), .cdoneOut(cdoneOut),
    .cdoneOe(cdoneOe), .tck(tck), .tmsIn(tmsIn), .tmsDrv(tmsDrv),
    .tdiIn(tdiIn), .tdiDrv(tdiDrv), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .cfgData(cfgData), .cfgDataValid(cfgDataValid),
    .configDone(configDone), .userMode(userMode));

  cpt_host_model host (.tck(tck), .tmsIn(tmsIn), .tmsDrv(tmsDrv),
    .tdiIn(tdiIn), .tdiDrv(tdiDrv), .tdoOut(tdoOut), .tdoOe(tdoOe));

  // Collects every delivered configuration word
  always @(posedge sys_clk) if (cfgDataValid === 1'b1) got.push_back(cfgData);

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Reconfiguration pulse of n system clocks
  task automatic crst_pulse(input int n);
    @(posedge sys_clk);
    crstReqN <= 1'b0;
    repeat (n) @(posedge sys_clk);
    crstReqN <= 1'b1;
  endtask

  task automatic t_reset;
    check("cdoneOe", 32'h1, 32'(cdoneOe));
    check("cdoneOut", 32'h0, 32'(cdoneOut));
    check("tdoOe", 32'h0, 32'(tdoOe));
    check("userMode", 32'h0, 32'(userMode));
    // Controller leaves test-logic-reset for idle before any scan
    host.move(1'b0);
  endtask

  task automatic t_bypass;
    host.scan(1'b1, 4, 32'(`CPT_IR_BYPASS), 1'b1, d, oe);
    check("ir capture", 32'h1, d);
    host.scan(1'b0, 8, 32'hB2, 1'b1, d, oe);
    check("bypass delay", 32'h64, d);
    check("oe shifting", 32'h1, 32'(oe));
    check("oe idle", 32'h0, 32'(tdoOe));
    host.scan(1'b0, 8, 32'h0, 1'b0, d, oe);
    check("undriven tdi", 32'hFE, d);
  endtask

  task automatic t_tms_float;
    host.scan(1'b1, 4, 32'(`CPT_IR_STATUS), 1'b1, d, oe);
    host.float_tms(6);
    host.scan(1'b0, 8, 32'hFF, 1'b1, d, oe);
    check("ir after float", 32'hFE, d);
  endtask

  task automatic t_config;
    logic [31:0] w [2];
    w[0] = 32'hA5C3_0F1E;
    w[1] = 32'h1234_5678;
    @(posedge sys_clk);
    cdoneHold <= 1'b1;
    host.scan(1'b1, 4, 32'(`CPT_IR_CFG_LOAD), 1'b1, d, oe);
    for (int i = 0; i < 2; i++) begin
      host.scan(1'b0, 32, w[i], 1'b1, d, oe);
      repeat (4) host.move(1'b0);
    end
    for (int i = 0; i < 200 && configDone !== 1'b1; i++) @(posedge sys_clk);
    check("configDone", 32'h1, 32'(configDone));
    check("cdoneOe done", 32'h0, 32'(cdoneOe));
    check("word count", 32'h2, 32'(got.size()));
    for (int i = 0; i < got.size() && i < 2; i++) begin
      check("cfgData", w[i], got[i]);
    end
    host.scan(1'b1, 4, 32'(`CPT_IR_STATUS), 1'b1, d, oe);
    host.scan(1'b0, 8, 32'h0, 1'b1, d, oe);
    check("status done", 32'h2, d);
    host.scan(1'b1, 4, 32'(`CPT_IR_ENTER_USER), 1'b1, d, oe);
    repeat (1400) @(posedge sys_clk);
    check("held flag", 32'h0, 32'(userMode));
    cdoneHold <= 1'b0;
    repeat (1240) @(posedge sys_clk);
    check("early user", 32'h0, 32'(userMode));
    for (int i = 0; i < 40 && userMode !== 1'b1; i++) @(posedge sys_clk);
    check("user mode", 32'h1, 32'(userMode));
  endtask

  task automatic t_reconfig;
    host.scan(1'b1, 4, 32'(`CPT_IR_STATUS), 1'b1, d, oe);
    crst_pulse(8);
    repeat (40) @(posedge sys_clk);
    check("short pulse", 32'h1, 32'(userMode));
    crst_pulse(20);
    repeat (10) @(posedge sys_clk);
    check("reconf done", 32'h0, 32'(configDone));
    check("reconf user", 32'h0, 32'(userMode));
    check("reconf oe", 32'h1, 32'(cdoneOe));
    host.scan(1'b0, 8, 32'hFF, 1'b1, d, oe);
    check("tap kept", 32'h0, d);
  endtask

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    crstReqN  = 1'b1;
    cdoneHold = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset;
    t_bypass;
    t_tms_float;
    t_config;
    t_reconfig;
    finish_test;
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    finish_test;
  end
endmodule
